// ===== hw/pit_defines.svh
// register offsets, field positions and reset values of the interval timer
`ifndef PIT_DEFINES_SVH
`define PIT_DEFINES_SVH

// ********************************************************************
// register indices (byte address is four times the index)
// ********************************************************************
`define PIT_CNT_IDX      8'h08
`define PIT_RLD_IDX      8'h09
`define PIT_ADDR_W       8

// ********************************************************************
// field positions
// ********************************************************************
`define PIT_VAL_MSB      23
`define PIT_VAL_LSB      0
`define PIT_OV_BIT       26
`define PIT_IN_BIT       25
`define PIT_IE_BIT       24

// ********************************************************************
// reset values
// ********************************************************************
`define PIT_CNT_RST      24'hFFFFFF
`define PIT_VAL_RST      24'hFFFFFF
`define PIT_FLAG_RST     1'h0
`define PIT_WORD_RST     32'h00000000

`endif

// ===== hw/pit_irq_gate.sv
// timer interrupt request gate with its own enable and two masks
`timescale 1ns/1ns
`default_nettype none

module pit_irq_gate (
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    input  wire pit_pkg::pit_gate_type gate_in,
    output logic                       irq_out
);

    // ****************************************************************
    // gating
    // ****************************************************************
    wire irq_nxt;

    // own enable, separate from other interrupt sources
    assign irq_nxt = gate_in.expiry_flag & gate_in.expiry_irq_gate
                   & ~gate_in.global_trap_mask
                   & ~gate_in.timer_mute;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= irq_nxt;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_gate_open;
        gate_in.expiry_flag && gate_in.expiry_irq_gate
            && !gate_in.global_trap_mask && !gate_in.timer_mute;
    endsequence

    a_irq_raised: assert property (
        @(posedge clk_in) disable iff (!rst_n_in) s_gate_open |=> irq_out)
        else $error("timer request missing while flag and enable are set");

    a_irq_gate_off: assert property (
        @(posedge clk_in) disable iff (!rst_n_in) !gate_in.expiry_irq_gate |=> !irq_out)
        else $error("timer request raised with its enable clear");

    a_irq_masked: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        (gate_in.global_trap_mask || gate_in.timer_mute) |=> !irq_out)
        else $error("timer request raised while masked");

endmodule : pit_irq_gate

`default_nettype wire

// ===== hw/pit_pkg.sv
// types shared by the interval timer modules
package pit_pkg;

    // ****************************************************************
    // reload register contents
    // ****************************************************************
    typedef struct packed {
        logic        lost_expiry_flag;
        logic        expiry_flag;
        logic        expiry_irq_gate;
        logic [23:0] reload_value;
    } pit_reload_type;

    // ****************************************************************
    // interrupt gating inputs
    // ****************************************************************
    typedef struct packed {
        logic expiry_flag;
        logic expiry_irq_gate;
        logic global_trap_mask;
        logic timer_mute;
    } pit_gate_type;

endpackage : pit_pkg

// ===== hw/pit_timer.sv
// periodic interval timer: countdown, reload, expiry flags and register port
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "pit_defines.svh"

// ********************************************************************
// Notes on behaviour
// - a 24-bit countdown drops by one every clock except at zero, unless software writes the count register.
// - at zero the countdown is loaded from the reload value and goes on.
// - the expiry flag sets in the same cycle the countdown reloads.
// - zero lasts one full cycle, so a count of 28 expires 29 cycles later.
// - expiry while the flag is still set also sets the lost-expiry flag.
// - the expiry flag sets on every expiry, enabled or not, unless a reload register write lands in that cycle.
// - the request is raised when expiry flag and its enable are both set.
// - the global trap mask blocks the timer request.
// - writing the reload value leaves the running countdown alone.
// - the timer request has its own enable apart from other sources.
// - the timer mute bit blocks the request just like the enable.
// - both registers answer only supervisor accesses; user access is refused.
// - the reload happens in the cycle right after the countdown hits zero.
// ********************************************************************

module pit_timer (
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic [`PIT_ADDR_W-1:0] addr_in,
    input  wire logic [31:0]            wdata_in,
    input  wire logic                   wr_in,
    input  wire logic                   rd_in,
    input  wire logic                   supervisor_in,
    input  wire logic                   global_trap_mask_in,
    input  wire logic                   timer_mute_in,
    output logic      [31:0]            rdata_out,
    output logic                        access_refused_out,
    output logic                        expiry_pulse_out,
    output logic                        timer_irq_out
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [`PIT_ADDR_W-1:0] pit_byte_addr(
        input logic [`PIT_ADDR_W-1:0] idx);
        pit_byte_addr = {idx[`PIT_ADDR_W-3:0], 2'b00};
    endfunction : pit_byte_addr

    function automatic logic [31:0] pit_pack_reload(input pit_pkg::pit_reload_type r);
        logic [31:0] w;
        w = `PIT_WORD_RST;
        w[`PIT_OV_BIT] = r.lost_expiry_flag;
        w[`PIT_IN_BIT] = r.expiry_flag;
        w[`PIT_IE_BIT] = r.expiry_irq_gate;
        w[`PIT_VAL_MSB:`PIT_VAL_LSB] = r.reload_value;
        pit_pack_reload = w;
    endfunction : pit_pack_reload

    function automatic pit_pkg::pit_reload_type pit_unpack_reload(input logic [31:0] w);
        pit_pkg::pit_reload_type r;
        r.lost_expiry_flag = w[`PIT_OV_BIT];
        r.expiry_flag      = w[`PIT_IN_BIT];
        r.expiry_irq_gate  = w[`PIT_IE_BIT];
        r.reload_value     = w[`PIT_VAL_MSB:`PIT_VAL_LSB];
        pit_unpack_reload = r;
    endfunction : pit_unpack_reload

    // ****************************************************************
    // state
    // ****************************************************************
    logic [23:0]             countdown_value_r;
    logic [23:0]             countdown_value_nxt;
    pit_pkg::pit_reload_type reload_r;
    pit_pkg::pit_reload_type reload_nxt;
    pit_pkg::pit_reload_type reload_expired;
    logic [31:0]             rdata_nxt;
    logic [31:0]             read_word;
    logic                    refused_nxt;
    pit_pkg::pit_gate_type   gate;

    // ****************************************************************
    // register port decode
    // ****************************************************************
    wire sel_cnt;
    wire sel_rld;
    wire sel_any;
    wire cnt_wr;
    wire rld_wr;
    wire reg_rd;
    wire expire;

    assign sel_cnt = (addr_in == pit_byte_addr(`PIT_CNT_IDX));
    assign sel_rld = (addr_in == pit_byte_addr(`PIT_RLD_IDX));
    assign sel_any = sel_cnt | sel_rld;

    // user mode gets nothing: writes dropped, reads return zero
    assign cnt_wr = wr_in & sel_cnt & supervisor_in;
    assign rld_wr = wr_in & sel_rld & supervisor_in;
    assign reg_rd = rd_in & supervisor_in;
    assign refused_nxt = (wr_in | rd_in) & sel_any & ~supervisor_in;

    // ****************************************************************
    // countdown
    // ****************************************************************
    // zero is a full cycle of its own before the reload
    assign expire = (countdown_value_r == 24'h000000);

    // a software load wins; the reload value only matters at expiry
    assign countdown_value_nxt = cnt_wr ? wdata_in[`PIT_VAL_MSB:`PIT_VAL_LSB]
                               : expire ? reload_r.reload_value
                               : countdown_value_r - 24'h000001;

    // ****************************************************************
    // reload register and expiry flags
    // ****************************************************************
    always_comb begin
        reload_expired = reload_r;
        reload_expired.expiry_flag = 1'b1;
        reload_expired.lost_expiry_flag = reload_r.lost_expiry_flag
                                        | reload_r.expiry_flag;
    end

    // the write replaces the whole word; a coinciding expiry is lost,
    // which is the hazard that the mute bit exists to avoid
    assign reload_nxt = rld_wr ? pit_unpack_reload(wdata_in)
                      : expire ? reload_expired
                      : reload_r;

    // ****************************************************************
    // read data
    // ****************************************************************
    assign read_word = sel_cnt ? {8'h00, countdown_value_r}
                     : sel_rld ? pit_pack_reload(reload_r)
                     : `PIT_WORD_RST;
    assign rdata_nxt = reg_rd ? read_word : `PIT_WORD_RST;

    // ****************************************************************
    // flip-flops
    // ****************************************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            countdown_value_r <= `PIT_CNT_RST;
        end else begin
            countdown_value_r <= countdown_value_nxt;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reload_r.lost_expiry_flag <= `PIT_FLAG_RST;
            reload_r.expiry_flag      <= `PIT_FLAG_RST;
            reload_r.expiry_irq_gate  <= `PIT_FLAG_RST;
            reload_r.reload_value     <= `PIT_VAL_RST;
        end else begin
            reload_r <= reload_nxt;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out          <= `PIT_WORD_RST;
            access_refused_out <= 1'b0;
            expiry_pulse_out   <= 1'b0;
        end else begin
            rdata_out          <= rdata_nxt;
            access_refused_out <= refused_nxt;
            expiry_pulse_out   <= expire;
        end
    end

    // ****************************************************************
    // interrupt request
    // ****************************************************************
    assign gate = '{expiry_flag:      reload_r.expiry_flag,
                    expiry_irq_gate:  reload_r.expiry_irq_gate,
                    global_trap_mask: global_trap_mask_in,
                    timer_mute:       timer_mute_in};

    // separate gate so the timer priority stays independent
    pit_irq_gate u_irq_gate (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .gate_in  (gate),
        .irq_out  (timer_irq_out)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    wire quiet;
    assign quiet = !cnt_wr && !rld_wr;

    sequence s_last_two;
        (countdown_value_r == 24'h000001) && quiet ##1 expire && quiet;
    endsequence

    a_count_step: assert property (
        (!expire && !cnt_wr) |=> countdown_value_r == $past(countdown_value_r) - 24'h000001)
        else $error("countdown did not drop by one");

    a_reload_zero: assert property (
        (expire && !cnt_wr) |=> countdown_value_r == $past(reload_r.reload_value))
        else $error("countdown not reloaded after zero");

    a_flag_with_load: assert property (
        (expire && quiet) |=> reload_r.expiry_flag
            && countdown_value_r == $past(reload_r.reload_value))
        else $error("expiry flag and reload not in the same cycle");

    a_zero_based: assert property (
        s_last_two |-> !expiry_pulse_out ##1 (expiry_pulse_out && reload_r.expiry_flag))
        else $error("expiry did not follow a full zero cycle");

    a_zero_hold: assert property (
        (countdown_value_r == 24'h000001 && quiet && !reload_r.expiry_flag) ##1 quiet
            |-> !reload_r.expiry_flag ##1 reload_r.expiry_flag)
        else $error("expiry flag set too early or too late");

    a_lost_expiry: assert property (
        (expire && reload_r.expiry_flag && !rld_wr) |=> reload_r.lost_expiry_flag)
        else $error("lost-expiry flag missed a second expiry");

    a_flag_any_gate: assert property (
        (expire && !rld_wr && !reload_r.expiry_irq_gate) |=> reload_r.expiry_flag)
        else $error("expiry flag needs no enable");

    a_flag_holds: assert property (
        (reload_r.expiry_flag && !rld_wr) |=> reload_r.expiry_flag)
        else $error("expiry flag dropped without a write");

    a_reload_no_disturb: assert property (
        (rld_wr && !cnt_wr && !expire)
            |=> countdown_value_r == $past(countdown_value_r) - 24'h000001)
        else $error("reload write disturbed the countdown");

    a_user_refused: assert property (
        (wr_in && sel_rld && !supervisor_in && !expire) |=> $stable(reload_r)
            && access_refused_out)
        else $error("user write reached the reload register");

    a_user_read_zero: assert property (
        (rd_in && !supervisor_in) |=> rdata_out == `PIT_WORD_RST)
        else $error("user read returned register data");

    a_write_wins: assert property (
        (rld_wr && expire) |=> pit_pack_reload(reload_r) ==
            ($past(wdata_in) & 32'h07FFFFFF))
        else $error("expiry overrode a reload register write");

    a_read_reload: assert property (
        (reg_rd && sel_rld) |=> rdata_out == pit_pack_reload($past(reload_r)))
        else $error("reload register read back wrong");

    a_pulse_on_expire: assert property (
        expire |=> expiry_pulse_out)
        else $error("expiry pulse missing after zero");

    a_pulse_only_expire: assert property (
        !expire |=> !expiry_pulse_out)
        else $error("expiry pulse without a zero count");

    a_load_wins: assert property (
        cnt_wr |=> countdown_value_r == $past(wdata_in[`PIT_VAL_MSB:`PIT_VAL_LSB]))
        else $error("countdown write not taken");

    a_load_keeps_flag: assert property (
        (cnt_wr && expire && !rld_wr) |=> reload_r.expiry_flag)
        else $error("countdown write at expiry dropped the flag");

    a_refused_needs_strobe: assert property (
        !(wr_in || rd_in) |=> !access_refused_out)
        else $error("refusal without an access");

    a_unmapped_quiet: assert property (
        ((wr_in || rd_in) && !sel_any) |=> !access_refused_out)
        else $error("unmapped access flagged as refused");

    a_rdata_idle: assert property (
        !reg_rd |=> rdata_out == `PIT_WORD_RST)
        else $error("read data shown without a read");

    a_user_count_kept: assert property (
        (wr_in && sel_cnt && !supervisor_in && !expire)
            |=> countdown_value_r == $past(countdown_value_r) - 24'h000001)
        else $error("user write reached the countdown");

    a_read_count: assert property (
        (reg_rd && sel_cnt) |=> rdata_out == {8'h00, $past(countdown_value_r)})
        else $error("countdown read back wrong");

    a_lost_sticky: assert property (
        (reload_r.lost_expiry_flag && !rld_wr) |=> reload_r.lost_expiry_flag)
        else $error("lost-expiry flag dropped without a write");

    a_no_lost_first: assert property (
        (expire && !reload_r.expiry_flag && !reload_r.lost_expiry_flag && !rld_wr)
            |=> !reload_r.lost_expiry_flag)
        else $error("lost-expiry flag set on a serviced expiry");

endmodule : pit_timer

`default_nettype wire

// ===== sim/tb.sv
// self-checking testbench for the periodic interval timer
`timescale 1ns/1ns
`default_nettype none

module tb;
    // ****************************************************************
    // stimulus and observation signals
    // ****************************************************************
    localparam logic [7:0] CNT_A = 8'h20;
    localparam logic [7:0] RLD_A = 8'h24;
    localparam logic [7:0] BAD_A = 8'h28;
    localparam int         LIMIT = 2000;

    logic        clk_in;
    logic        rst_n_in;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        sup;
    logic        gtm;
    logic        mute;
    logic [31:0] rdata;
    logic        refused;
    logic        pulse;
    logic        irq;
    int          cyc;
    int          miscompares;
    int          n_tests;
    int          w_at;
    int          p_at;
    int          t0;
    logic [31:0] d0;
    logic [31:0] d1;
    logic        r0;

    pit_timer dut (
        .clk_in              (clk_in),
        .rst_n_in            (rst_n_in),
        .addr_in             (addr),
        .wdata_in            (wdata),
        .wr_in               (wr),
        .rd_in               (rd),
        .supervisor_in       (sup),
        .global_trap_mask_in (gtm),
        .timer_mute_in       (mute),
        .rdata_out           (rdata),
        .access_refused_out  (refused),
        .expiry_pulse_out    (pulse),
        .timer_irq_out       (irq)
    );

    // ****************************************************************
    // clock and hang guard
    // ****************************************************************
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // the whole run needs about a hundred cycles; the ceiling leaves ample room
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            miscompares++;
            $display("timeout after %0d cycles", cyc);
            end_sim();
        end
    end

    // ****************************************************************
    // helper tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic s);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        sup <= s;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
        #1;
        w_at = cyc;
    endtask : reg_wr

    // read data and the refusal pulse stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, input logic s, output logic [31:0] d,
                          output logic f);
        @(posedge clk_in);
        addr <= a;
        sup <= s;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        d = rdata;
        f = refused;
    endtask : reg_rd

    task automatic wait_pulse();
        p_at = -1;
        for (int i = 0; i < 100 && p_at < 0; i++) begin
            @(posedge clk_in);
            #1;
            if (pulse === 1'b1) p_at = cyc;
        end
    endtask : wait_pulse

    task automatic set_masks(input logic g, input logic m);
        @(posedge clk_in);
        gtm <= g;
        mute <= m;
        @(posedge clk_in);
        @(posedge clk_in);
        #1;
    endtask : set_masks

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rst_n_in = 1'b0;
        addr = 8'h00;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
        sup = 1'b1;
        gtm = 1'b0;
        mute = 1'b0;
        cyc = 0;
        miscompares = 0;
        n_tests = 0;
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;

        // first interval 28, second 5 written while the first runs
        reg_wr(CNT_A, 32'h0000001C, 1'b1);
        t0 = w_at;
        reg_wr(RLD_A, 32'h01000005, 1'b1);
        reg_rd(CNT_A, 1'b1, d0, r0);
        reg_rd(CNT_A, 1'b1, d1, r0);
        chk("count first read", 32'h00000019, d0);
        chk("count step", 32'h00000017, d1);
        wait_pulse();
        chk("first expiry cycle", 32'(t0 + 29), 32'(p_at));
        @(posedge clk_in);
        #1;
        chk("irq enabled", 32'h00000001, 32'(irq));
        reg_rd(RLD_A, 1'b1, d0, r0);
        chk("reload after expiry", 32'h03000005, d0);
        t0 = p_at;
        wait_pulse();
        chk("second expiry cycle", 32'(t0 + 6), 32'(p_at));
        reg_rd(RLD_A, 1'b1, d0, r0);
        chk("lost expiry", 32'h07000005, d0);
        set_masks(1'b1, 1'b0);
        chk("irq trap masked", 32'h00000000, 32'(irq));
        set_masks(1'b0, 1'b1);
        chk("irq muted", 32'h00000000, 32'(irq));
        set_masks(1'b0, 1'b0);
        chk("irq unmasked", 32'h00000001, 32'(irq));
        $display("test expiry and gating done");

        // flags cleared by software, then an expiry with the gate off
        reg_wr(CNT_A, 32'h00000100, 1'b1);
        reg_wr(RLD_A, 32'h00000020, 1'b1);
        reg_rd(RLD_A, 1'b1, d0, r0);
        chk("flags cleared", 32'h00000020, d0);
        reg_wr(CNT_A, 32'h00000003, 1'b1);
        t0 = w_at;
        wait_pulse();
        chk("short expiry cycle", 32'(t0 + 4), 32'(p_at));
        reg_rd(RLD_A, 1'b1, d0, r0);
        chk("flag without gate", 32'h02000020, d0);
        chk("irq gated off", 32'h00000000, 32'(irq));
        $display("test ungated expiry done");

        // user mode is refused; an unmapped place reads zero quietly
        reg_rd(RLD_A, 1'b0, d0, r0);
        chk("user read data", 32'h00000000, d0);
        chk("user read refused", 32'h00000001, 32'(r0));
        reg_wr(RLD_A, 32'h00000000, 1'b0);
        chk("user write refused", 32'h00000001, 32'(refused));
        reg_wr(CNT_A, 32'h00000001, 1'b0);
        chk("user count refused", 32'h00000001, 32'(refused));
        reg_rd(CNT_A, 1'b1, d0, r0);
        chk("user count ignored", 32'h00000017, d0);
        reg_rd(RLD_A, 1'b1, d0, r0);
        chk("user write ignored", 32'h02000020, d0);
        reg_rd(BAD_A, 1'b1, d0, r0);
        chk("unmapped data", 32'h00000000, d0);
        chk("unmapped not refused", 32'h00000000, 32'(r0));
        $display("test access protection done");

        // writes that land in the expiry cycle itself
        reg_wr(CNT_A, 32'h00000002, 1'b1);
        @(posedge clk_in);
        reg_wr(RLD_A, 32'h01000040, 1'b1);
        reg_rd(RLD_A, 1'b1, d0, r0);
        chk("write beats expiry", 32'h01000040, d0);
        reg_rd(CNT_A, 1'b1, d0, r0);
        chk("old reload used", 32'h0000001D, d0);
        reg_wr(CNT_A, 32'h00000002, 1'b1);
        @(posedge clk_in);
        reg_wr(CNT_A, 32'h00000010, 1'b1);
        reg_rd(RLD_A, 1'b1, d0, r0);
        chk("flag beside count write", 32'h03000040, d0);
        reg_rd(CNT_A, 1'b1, d0, r0);
        chk("count write at expiry", 32'h0000000D, d0);
        chk("irq after late flag", 32'h00000001, 32'(irq));
        $display("test coinciding writes done");

        end_sim();
    end
endmodule : tb

`default_nettype wire
